// ===== datc_top.sv
// Debug access gating, debug power mode, wake flag and trace pin control.
// Assumes the serial debug front end delivers the power request as a pin from
// outside the clock domain and AP requests by register write; AXI4-Lite master on CLK_I.
//
// Implementation choices: the AXI4-Lite slave port and the address map.
`timescale 1ns/1ps
module datc_top #(
  parameter int PWR_CYC = datc_pkg::POWER_UP_CYC
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RESET_I,
  // AXI4-Lite write
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  // AXI4-Lite read
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Debug port side
  input  wire logic        PWR_REQ_I,
  output logic             PWR_ACK_O,
  output logic             DEBUG_MODE_O,
  output logic             WAKE_O,
  // Access port routing
  output logic [2:0]       AP_SEL_O,
  output logic             ALLOW_SECURE_O,
  output logic             ALLOW_NONSEC_O,
  // Trace pins and drive
  output logic [3:0]       TRACE_DATA_O,
  output logic             TRACE_CLK_O,
  output logic             TRACE_PIN_SEL_O,
  output logic             HIGH_DRIVE_O,
  // Interrupt
  output logic             IRQ_O
);
  logic pwr_s1_q, pwr_s2_q;
  datc_pkg::datc_mode_t mode_q, mode_d;
  logic [7:0]  pcnt_q, pcnt_d;
  logic [6:0]  ctl_q, ctl_d;
  logic [1:0]  rate_q, rate_d;
  logic [3:0]  stat_q, stat_d, en_q, en_d;
  logic        wake_flag_q, wake_flag_d;
  logic [31:0] tword_q, tword_d;
  logic        tvalid_q, tvalid_d;
  logic [11:0] apreq_q, apreq_d;
  logic [4:0]  apresp_q, apresp_d;
  logic [2:0]  sel_q, sel_d;
  logic        ack_q, ack_d, irq_q, irq_d, dbg_q, dbg_d;
  logic        aw_q, aw_d, w_q, w_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [31:0] wd_q, wd_d, rd_q, rd_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic        t_ready, t_active;
  logic [3:0]  t_data;
  logic        t_clk;

  // Trace port serialiser
  datc_trace_port u_trace (
    .clk_i    (CLK_I),
    .reset_i  (RESET_I),
    .rate_i   (rate_q),
    .word_i   (tword_q),
    .valid_i  (tvalid_q),
    .ready_o  (t_ready),
    .data_o   (t_data),
    .clk_o    (t_clk),
    .active_o (t_active)
  );

  // [RULE1] [RULE2] [RULE3] Lockout decision
  function automatic logic grant(input logic [6:0] c, input logic [11:0] r);
    logic sec;
    sec = r[datc_pkg::REQ_SEC_BIT];
    if (c[datc_pkg::CTL_LOCK_ALL]) grant = 1'b0;
    else if (c[datc_pkg::CTL_LOCK_SECURE]) grant = !sec;
    else grant = 1'b1;
  endfunction : grant

  // [RULE5] Identifier to one-hot port
  function automatic logic [2:0] route(input logic [7:0] id);
    case (id)
      datc_pkg::AP_SYSTEM:  route = 3'b001;
      datc_pkg::AP_PERIPH:  route = 3'b010;
      datc_pkg::AP_CONTROL: route = 3'b100;
      default:              route = 3'b000;
    endcase
  endfunction : route

  // Power request synchroniser
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pwr_s1_q <= 1'b0;
      pwr_s2_q <= 1'b0;
    end else begin
      pwr_s1_q <= PWR_REQ_I;
      pwr_s2_q <= pwr_s1_q;
    end
  end

  logic [3:0] ev;
  logic       ap_ok;
  logic [2:0] ap_sel;
  logic       wake_clr;
  // Grants and ready flags are registered so every pin leaves a flip-flop
  logic       allow_ns_q, allow_ns_d, allow_sec_q, allow_sec_d;
  logic       awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

  always_comb begin
    mode_d = mode_q;
    pcnt_d = pcnt_q;
    ack_d  = 1'b0;
    dbg_d  = 1'b0;
    ev     = 4'h0;
    wake_flag_d = wake_flag_q && !wake_clr;
    // [RULE7] Mode follows request
    case (mode_q)
      datc_pkg::DATC_NORMAL: begin
        pcnt_d = 8'h0;
        if (pwr_s2_q) begin
          mode_d = datc_pkg::DATC_POWER;
          // [RULE9] Wake from off state
          if (ctl_q[datc_pkg::CTL_SYS_OFF]) begin
            wake_flag_d = 1'b1;
            ev[datc_pkg::EVT_WAKE] = 1'b1;
          end
        end
      end
      datc_pkg::DATC_POWER: begin
        dbg_d = 1'b1;
        if (!pwr_s2_q) mode_d = datc_pkg::DATC_NORMAL;
        else if (pcnt_q == 8'(PWR_CYC - 1)) begin
          mode_d = datc_pkg::DATC_DEBUG;
          ev[datc_pkg::EVT_PWR_UP] = 1'b1;
        end else pcnt_d = pcnt_q + 8'h1;
      end
      datc_pkg::DATC_DEBUG: begin
        dbg_d = 1'b1;
        // [RULE18] Acknowledge while powered
        ack_d = pwr_s2_q;
        if (!pwr_s2_q) begin
          mode_d = datc_pkg::DATC_NORMAL;
          dbg_d  = 1'b0;
          ev[datc_pkg::EVT_PWR_DOWN] = 1'b1;
        end
      end
      default: mode_d = datc_pkg::DATC_NORMAL;
    endcase
    if (mode_d == datc_pkg::DATC_NORMAL) dbg_d = 1'b0;
    else dbg_d = 1'b1;
    // Access request evaluation
    ap_sel = route(apreq_q[datc_pkg::REQ_AP_LSB +: 8]);
    ap_ok  = grant(ctl_q, apreq_q) && ack_q && (ap_sel != 3'b000);
    // [RULE4] Execute permission grants read
    if (apreq_q[datc_pkg::REQ_READ_BIT] && !apreq_q[datc_pkg::REQ_RPERM]
        && !apreq_q[datc_pkg::REQ_EXEC_BIT]) ap_ok = 1'b0;
    sel_d = ap_ok ? ap_sel : 3'b000;
    apresp_d = {ap_sel, ap_ok, !ap_ok};
    if (!ap_ok && apreq_q != 12'h0) ev[datc_pkg::EVT_REFUSED] = 1'b1;
    irq_d = |(stat_q & en_q);
    // [RULE2] [RULE3] Domain permissions
    allow_ns_d  = !ctl_q[datc_pkg::CTL_LOCK_ALL] && ack_q;
    allow_sec_d = allow_ns_d && !ctl_q[datc_pkg::CTL_LOCK_SECURE];
  end

  // AXI4-Lite slave
  always_comb begin
    aw_d = aw_q; awa_d = awa_q; w_d = w_q; wd_d = wd_q;
    bv_d = bv_q; br_d = br_q; rv_d = rv_q; rd_d = rd_q; rr_d = rr_q;
    ctl_d = ctl_q; rate_d = rate_q; en_d = en_q; apreq_d = apreq_q;
    tword_d = tword_q;
    tvalid_d = tvalid_q && !t_ready;
    stat_d = stat_q | ev;
    wake_clr = 1'b0;
    if (AWVALID_I && !aw_q) begin aw_d = 1'b1; awa_d = AWADDR_I; end
    if (WVALID_I && !w_q) begin w_d = 1'b1; wd_d = WDATA_I; end
    if (bv_q && BREADY_I) bv_d = 1'b0;
    if (aw_q && w_q && !bv_q) begin
      aw_d = 1'b0; w_d = 1'b0; bv_d = 1'b1; br_d = datc_pkg::RESP_OKAY;
      case (awa_q)
        datc_pkg::ADDR_CONTROL: begin
          // [RULE15] Drive bit frozen in debug
          if (dbg_q && ctl_q[datc_pkg::CTL_DRIVE_LOCK])
            ctl_d = {ctl_q[6:4], ctl_q[datc_pkg::CTL_HIGH_DRIVE], wd_q[2:0]};
          else ctl_d = wd_q[6:0];
          wake_clr = wd_q[datc_pkg::CTL_WAKE_CLR];
        end
        datc_pkg::ADDR_EVT_CLR:   stat_d = (stat_q & ~wd_q[3:0]) | ev;
        datc_pkg::ADDR_EVT_EN:    en_d = wd_q[3:0];
        datc_pkg::ADDR_TRACE_CFG: rate_d = wd_q[1:0];
        datc_pkg::ADDR_TRACE_DAT: begin
          tword_d = wd_q;
          tvalid_d = 1'b1;
        end
        datc_pkg::ADDR_AP_REQ:    apreq_d = wd_q[11:0];
        default:                  br_d = datc_pkg::RESP_SLVERR;
      endcase
    end
    if (rv_q && RREADY_I) rv_d = 1'b0;
    if (ARVALID_I && !rv_q) begin
      rv_d = 1'b1; rr_d = datc_pkg::RESP_OKAY; rd_d = 32'h0;
      case (ARADDR_I)
        datc_pkg::ADDR_CONTROL:   rd_d = {25'h0, ctl_q};
        datc_pkg::ADDR_STATUS:    rd_d = {26'h0, t_active, wake_flag_q,
                                          ack_q, dbg_q, mode_q == datc_pkg::DATC_POWER,
                                          pwr_s2_q};
        datc_pkg::ADDR_EVT_STAT:  rd_d = {28'h0, stat_q};
        datc_pkg::ADDR_EVT_EN:    rd_d = {28'h0, en_q};
        datc_pkg::ADDR_TRACE_CFG: rd_d = {30'h0, rate_q};
        datc_pkg::ADDR_AP_REQ:    rd_d = {20'h0, apreq_q};
        datc_pkg::ADDR_AP_RESP:   rd_d = {27'h0, apresp_q};
        // [RULE16] [RULE17] Capability word
        datc_pkg::ADDR_COMPARE:   rd_d = {20'h0, datc_pkg::SWD_VER,
                                          datc_pkg::NUM_WATCH, datc_pkg::NUM_BREAK};
        default:                  rr_d = datc_pkg::RESP_SLVERR;
      endcase
    end
    awrdy_d = !aw_d;
    wrdy_d  = !w_d;
    arrdy_d = !rv_d;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      mode_q <= datc_pkg::DATC_NORMAL;
      pcnt_q <= 8'h0;
      ack_q  <= 1'b0;
      dbg_q  <= 1'b0;
      irq_q  <= 1'b0;
      sel_q  <= 3'b000;
      apresp_q <= 5'h0;
      wake_flag_q <= 1'b0;
      // [RULE14] Standard drive at reset
      ctl_q  <= 7'h0;
      rate_q <= datc_pkg::RATE_RESET;
      stat_q <= 4'h0;
      en_q   <= 4'h0;
      apreq_q <= 12'h0;
      tword_q <= 32'h0;
      tvalid_q <= 1'b0;
      aw_q <= 1'b0; awa_q <= 8'h0; w_q <= 1'b0; wd_q <= 32'h0;
      bv_q <= 1'b0; br_q <= 2'h0; rv_q <= 1'b0; rd_q <= 32'h0; rr_q <= 2'h0;
      allow_ns_q  <= 1'b0;
      allow_sec_q <= 1'b0;
      awrdy_q <= 1'b1;
      wrdy_q  <= 1'b1;
      arrdy_q <= 1'b1;
    end else begin
      mode_q <= mode_d;
      pcnt_q <= pcnt_d;
      ack_q  <= ack_d;
      dbg_q  <= dbg_d;
      irq_q  <= irq_d;
      sel_q  <= sel_d;
      apresp_q <= apresp_d;
      wake_flag_q <= wake_flag_d;
      ctl_q  <= ctl_d;
      rate_q <= rate_d;
      stat_q <= stat_d;
      en_q   <= en_d;
      apreq_q <= apreq_d;
      tword_q <= tword_d;
      tvalid_q <= tvalid_d;
      aw_q <= aw_d; awa_q <= awa_d; w_q <= w_d; wd_q <= wd_d;
      bv_q <= bv_d; br_q <= br_d; rv_q <= rv_d; rd_q <= rd_d; rr_q <= rr_d;
      allow_ns_q  <= allow_ns_d;
      allow_sec_q <= allow_sec_d;
      awrdy_q <= awrdy_d;
      wrdy_q  <= wrdy_d;
      arrdy_q <= arrdy_d;
    end
  end

  // Ready only while the holding slot is empty
  assign AWREADY_O = awrdy_q;
  assign WREADY_O  = wrdy_q;
  assign ARREADY_O = arrdy_q;
  assign BVALID_O  = bv_q;
  assign BRESP_O   = br_q;
  assign RVALID_O  = rv_q;
  assign RDATA_O   = rd_q;
  assign RRESP_O   = rr_q;
  assign PWR_ACK_O = ack_q;
  assign DEBUG_MODE_O = dbg_q;
  assign WAKE_O    = wake_flag_q;
  assign AP_SEL_O  = sel_q;
  // [RULE2] [RULE3] Domain permissions
  assign ALLOW_NONSEC_O = allow_ns_q;
  assign ALLOW_SECURE_O = allow_sec_q;
  // [RULE12] Pin mux to trace
  assign TRACE_PIN_SEL_O = ctl_q[datc_pkg::CTL_PIN_TRACE];
  assign TRACE_DATA_O = t_data;
  assign TRACE_CLK_O  = t_clk;
  assign HIGH_DRIVE_O = ctl_q[datc_pkg::CTL_HIGH_DRIVE];
  // [RULE10] Debug never masks interrupts
  assign IRQ_O = irq_q;
endmodule : datc_top

// ===== datc_pkg.sv
// Constants, register map and types for the debug access and trace control block.
// Assumes a 50 MHz system clock and AXI4-Lite register access with 32-bit data.
// Function
// [RULE1] General lockout refuses all debugger access
// [RULE2] Secure lockout limits debug to non-secure
// [RULE3] Both unprotected allows full debug
// [RULE4] Executable regions readable despite read denial
// [RULE5] Route access ports by ids 0, 3, 4
// [RULE6] Debugger requests power before port access
// [RULE7] Debug mode exactly while power request held
// [RULE8] Debugger releases request, then pin reset
// [RULE9] Request in off state wakes, sets flag
// [RULE10] Higher-priority interrupts served while halted
// [RULE11] Four trace data lines plus trace clock
// [RULE12] Trace pins shared with general-purpose I/O
// [RULE13] Trace rate from retained speed setting
// [RULE14] Standard drive at reset, high optional
// [RULE15] Software keeps trace pin drive untouched
// [RULE16] Eight breakpoint and four watchpoint comparators
// [RULE17] Two-pin serial wire debug, version 1
// [RULE18] Power acknowledge follows request when powered
package datc_pkg;
  // Register byte offsets
  localparam logic [7:0] ADDR_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS    = 8'h04;
  localparam logic [7:0] ADDR_EVT_STAT  = 8'h08;
  localparam logic [7:0] ADDR_EVT_CLR   = 8'h0C;
  localparam logic [7:0] ADDR_EVT_EN    = 8'h10;
  localparam logic [7:0] ADDR_TRACE_CFG = 8'h14;
  localparam logic [7:0] ADDR_TRACE_DAT = 8'h18;
  localparam logic [7:0] ADDR_AP_REQ    = 8'h1C;
  localparam logic [7:0] ADDR_AP_RESP   = 8'h20;
  localparam logic [7:0] ADDR_COMPARE   = 8'h24;
  // Control bits
  localparam int CTL_LOCK_ALL    = 0;
  localparam int CTL_LOCK_SECURE = 1;
  localparam int CTL_PIN_TRACE   = 2;
  localparam int CTL_HIGH_DRIVE  = 3;
  localparam int CTL_SYS_OFF     = 4;
  localparam int CTL_WAKE_CLR    = 5;
  localparam int CTL_DRIVE_LOCK  = 6;
  // Event bits
  localparam int EVT_PWR_UP   = 0;
  localparam int EVT_PWR_DOWN = 1;
  localparam int EVT_WAKE     = 2;
  localparam int EVT_REFUSED  = 3;
  localparam int EVT_W        = 4;
  // Access port request fields
  localparam int REQ_AP_LSB   = 0;
  localparam int REQ_SEC_BIT  = 8;
  localparam int REQ_EXEC_BIT = 9;
  localparam int REQ_READ_BIT = 10;
  localparam int REQ_RPERM    = 11;
  // Access port identifiers
  localparam logic [7:0] AP_SYSTEM  = 8'h00;
  localparam logic [7:0] AP_PERIPH  = 8'h03;
  localparam logic [7:0] AP_CONTROL = 8'h04;
  // Comparator counts and serial wire debug version
  localparam logic [3:0] NUM_BREAK = 4'h8;
  localparam logic [3:0] NUM_WATCH = 4'h4;
  localparam logic [3:0] SWD_VER   = 4'h1;
  // Trace rate encodings (divider = 2 << rate)
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam int         POWER_UP_NS = 100;
  localparam int         CLK_NS      = 20;
  localparam int         POWER_UP_CYC = (POWER_UP_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    DATC_NORMAL = 3'b001,
    DATC_POWER  = 3'b010,
    DATC_DEBUG  = 3'b100
  } datc_mode_t;
endpackage : datc_pkg

// ===== datc_trace_port.sv
// Four-line parallel trace port with a divided trace clock.
// Assumes words are offered with valid/ready from the same clock domain.
`timescale 1ns/1ps
module datc_trace_port (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Configuration
  input  wire logic [1:0]  rate_i,
  // Word input
  input  wire logic [31:0] word_i,
  input  wire logic        valid_i,
  output logic             ready_o,
  // Pins
  output logic [3:0]       data_o,
  output logic             clk_o,
  output logic             active_o
);
  logic [31:0] shift_q, shift_d;
  logic [3:0]  nib_q, nib_d;
  logic [3:0]  div_q, div_d;
  logic        tclk_q, tclk_d;
  logic [3:0]  data_q, data_d;
  logic        busy_q, busy_d;

  // [RULE13] Rate sets divider
  function automatic logic [3:0] half_period(input logic [1:0] r);
    half_period = 4'(1 << r) - 4'h1;
  endfunction : half_period

  always_comb begin
    shift_d = shift_q;
    nib_d   = nib_q;
    div_d   = div_q;
    tclk_d  = tclk_q;
    data_d  = data_q;
    busy_d  = busy_q;
    if (!busy_q) begin
      tclk_d = 1'b0;
      if (valid_i) begin
        shift_d = word_i;
        nib_d   = 4'h0;
        div_d   = 4'h0;
        busy_d  = 1'b1;
      end
    end else if (div_q == half_period(rate_i)) begin
      div_d  = 4'h0;
      tclk_d = !tclk_q;
      // [RULE11] Nibble on rising edge
      if (!tclk_q) begin
        data_d  = shift_q[3:0];
        shift_d = {4'h0, shift_q[31:4]};
        nib_d   = nib_q + 4'h1;
      end else if (nib_q == 4'h8) begin
        busy_d = 1'b0;
      end
    end else begin
      div_d = div_q + 4'h1;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_q <= 32'h0;
      nib_q   <= 4'h0;
      div_q   <= 4'h0;
      tclk_q  <= 1'b0;
      data_q  <= 4'h0;
      busy_q  <= 1'b0;
    end else begin
      shift_q <= shift_d;
      nib_q   <= nib_d;
      div_q   <= div_d;
      tclk_q  <= tclk_d;
      data_q  <= data_d;
      busy_q  <= busy_d;
    end
  end

  assign ready_o  = !busy_q;
  assign data_o   = data_q;
  assign clk_o    = tclk_q;
  assign active_o = busy_q;
endmodule : datc_trace_port

// ===== datc_probe.sv
// Behavioural debug probe: drives the power-up request, captures trace.
// Assumes trace pins are sampled with the block's own clock.
`timescale 1ns/1ps
module datc_probe (
  // Clock
  input  wire logic        clk_i,
  // Trace pins
  input  wire logic [3:0]  trace_data_i,
  input  wire logic        trace_clk_i,
  // Debug port
  output logic             pwr_req_o
);
  logic        clk_q;
  logic [31:0] word_q;
  int          nibbles;
  initial begin
    pwr_req_o = 1'b0;
    clk_q = 1'b0;
    word_q = '0;
    nibbles = 0;
  end
  task automatic request(input logic on);
    @(posedge clk_i);
    pwr_req_o <= on;
  endtask : request
  always @(posedge clk_i) begin
    clk_q <= trace_clk_i;
    if (trace_clk_i && !clk_q) begin
      word_q <= {trace_data_i, word_q[31:4]};
      nibbles <= nibbles + 1;
    end
  end
endmodule : datc_probe

// ===== datc_props.sv
// Port checker for the debug access and trace control block.
// Assumes a single clock domain with asynchronous active-high reset.
`timescale 1ns/1ps
module datc_props #(
  parameter int PWR_CYC = 5
) (
  input wire logic        CLK_I,
  input wire logic        RESET_I,
  input wire logic        PWR_REQ_I,
  input wire logic        PWR_ACK_O,
  input wire logic        DEBUG_MODE_O,
  input wire logic        ALLOW_SECURE_O,
  input wire logic        ALLOW_NONSEC_O,
  input wire logic [2:0]  AP_SEL_O,
  input wire logic        BVALID_O,
  input wire logic        BREADY_I,
  input wire logic [1:0]  BRESP_O,
  input wire logic        RVALID_O,
  input wire logic        RREADY_I,
  input wire logic [31:0] RDATA_O,
  input wire logic        ARVALID_I,
  input wire logic        ARREADY_O,
  input wire logic [3:0]  TRACE_DATA_O,
  input wire logic        TRACE_CLK_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  property p_secure_needs_nonsec;
    ALLOW_SECURE_O |-> ALLOW_NONSEC_O;
  endproperty
  a_secure_needs_nonsec: assert property (p_secure_needs_nonsec)
    else $error("secure access granted without non-secure access");
  property p_ack_in_mode;
    PWR_ACK_O |-> DEBUG_MODE_O;
  endproperty
  a_ack_in_mode: assert property (p_ack_in_mode)
    else $error("power acknowledge outside debug mode");
  property p_mode_enter;
    $rose(PWR_REQ_I) ##1 PWR_REQ_I [*7] |-> ##[0:2] DEBUG_MODE_O;
  endproperty
  a_mode_enter: assert property (p_mode_enter)
    else $error("debug mode not entered on request");
  property p_mode_leave;
    $fell(PWR_REQ_I) |-> ##[1:5] (!DEBUG_MODE_O && !PWR_ACK_O);
  endproperty
  a_mode_leave: assert property (p_mode_leave)
    else $error("debug mode held after request release");
  property p_bvalid_hold;
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O);
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold)
    else $error("write response dropped before ready");
  property p_rvalid_hold;
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold)
    else $error("read data dropped before ready");
  property p_read_answer;
    ARVALID_I && ARREADY_O |=> RVALID_O;
  endproperty
  a_read_answer: assert property (p_read_answer)
    else $error("read answer late");
  property p_trace_edge;
    $changed(TRACE_DATA_O) |-> $rose(TRACE_CLK_O);
  endproperty
  a_trace_edge: assert property (p_trace_edge)
    else $error("trace data changed off the trace clock edge");
  property p_one_port;
    $onehot0(AP_SEL_O);
  endproperty
  a_one_port: assert property (p_one_port)
    else $error("more than one access port selected");
endmodule : datc_props
bind datc_top datc_props #(.PWR_CYC(PWR_CYC)) datc_props_inst (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .PWR_REQ_I(PWR_REQ_I), .PWR_ACK_O(PWR_ACK_O),
  .DEBUG_MODE_O(DEBUG_MODE_O), .ALLOW_SECURE_O(ALLOW_SECURE_O),
  .ALLOW_NONSEC_O(ALLOW_NONSEC_O), .AP_SEL_O(AP_SEL_O), .BVALID_O(BVALID_O),
  .BREADY_I(BREADY_I), .BRESP_O(BRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .RDATA_O(RDATA_O), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O),
  .TRACE_DATA_O(TRACE_DATA_O), .TRACE_CLK_O(TRACE_CLK_O));

// ===== debug_access_and_trace_control_test.sv
// Self-checking bench: AXI4-Lite register tasks plus a debug probe model.
// Assumes the probe owns the power request and watches the trace pins.
`timescale 1ns/1ps
module debug_access_and_trace_control_test;
  logic CLK_I, RESET_I, AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I, PWR_REQ_I;
  logic AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O, PWR_ACK_O, DEBUG_MODE_O;
  logic WAKE_O, ALLOW_SECURE_O, ALLOW_NONSEC_O, TRACE_CLK_O, TRACE_PIN_SEL_O;
  logic HIGH_DRIVE_O, IRQ_O;
  logic [7:0]  AWADDR_I, ARADDR_I;
  logic [31:0] WDATA_I, RDATA_O, d;
  logic [1:0]  BRESP_O, RRESP_O, r;
  logic [2:0]  AP_SEL_O;
  logic [3:0]  TRACE_DATA_O;
  int mismatches, checks_done, n, i;
  datc_top #(.PWR_CYC(1)) datc_top_inst (
    .CLK_I(CLK_I), .RESET_I(RESET_I), .AWADDR_I(AWADDR_I), .AWVALID_I(AWVALID_I),
    .AWREADY_O(AWREADY_O), .WDATA_I(WDATA_I), .WSTRB_I(4'hF), .WVALID_I(WVALID_I),
    .WREADY_O(WREADY_O), .BRESP_O(BRESP_O), .BVALID_O(BVALID_O), .BREADY_I(BREADY_I),
    .ARADDR_I(ARADDR_I), .ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .RDATA_O(RDATA_O),
    .RRESP_O(RRESP_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .PWR_REQ_I(PWR_REQ_I),
    .PWR_ACK_O(PWR_ACK_O), .DEBUG_MODE_O(DEBUG_MODE_O), .WAKE_O(WAKE_O),
    .AP_SEL_O(AP_SEL_O), .ALLOW_SECURE_O(ALLOW_SECURE_O), .ALLOW_NONSEC_O(ALLOW_NONSEC_O),
    .TRACE_DATA_O(TRACE_DATA_O), .TRACE_CLK_O(TRACE_CLK_O),
    .TRACE_PIN_SEL_O(TRACE_PIN_SEL_O), .HIGH_DRIVE_O(HIGH_DRIVE_O), .IRQ_O(IRQ_O));
  datc_probe datc_probe_inst (.clk_i(CLK_I), .trace_data_i(TRACE_DATA_O),
    .trace_clk_i(TRACE_CLK_O), .pwr_req_o(PWR_REQ_I));
  initial begin
    CLK_I = 1'b0;
    forever #10 CLK_I = ~CLK_I;
  end
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic tmo(input logic ok);
    if (ok !== 1'b1) begin
      mismatches++;
      tally_and_finish();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 0;
    @(posedge CLK_I);
    AWADDR_I <= a;
    WDATA_I <= v;
    AWVALID_I <= 1;
    WVALID_I <= 1;
    BREADY_I <= 1;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge CLK_I);
      if (AWVALID_I && AWREADY_O) AWVALID_I <= 0;
      if (WVALID_I && WREADY_O) WVALID_I <= 0;
      if (BVALID_O && BREADY_I) begin
        done = 1;
        rs = BRESP_O;
        BREADY_I <= 0;
      end
    end
    tmo(done);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 0;
    @(posedge CLK_I);
    ARADDR_I <= a;
    ARVALID_I <= 1;
    RREADY_I <= 1;
    for (n = 0; n < 50 && !done; n++) begin
      @(posedge CLK_I);
      if (ARVALID_I && ARREADY_O) ARVALID_I <= 0;
      if (RVALID_O && RREADY_I) begin
        done = 1;
        v = RDATA_O;
        rs = RRESP_O;
        RREADY_I <= 0;
      end
    end
    tmo(done);
  endtask : rd
  task automatic wrs(input logic [7:0] a, input logic [31:0] v);
    wr(a, v, r);
    repeat (3) @(posedge CLK_I);
  endtask : wrs
  initial begin
    {AWVALID_I, WVALID_I, BREADY_I, ARVALID_I, RREADY_I} = '0;
    {AWADDR_I, ARADDR_I, WDATA_I} = '0;
    mismatches = 0;
    checks_done = 0;
    RESET_I = 1;
    repeat (8) @(posedge CLK_I);
    RESET_I <= 0;
    @(posedge CLK_I);
    chk("high_drive", HIGH_DRIVE_O, 0);
    rd(datc_pkg::ADDR_COMPARE, d, r);
    chk("compare", d, 32'h148);
    rd(8'h3C, d, r);
    chk("unmapped", r, datc_pkg::RESP_SLVERR);
    wr(datc_pkg::ADDR_STATUS, 32'h0, r);
    chk("ro_write", r, datc_pkg::RESP_SLVERR);
    wrs(datc_pkg::ADDR_CONTROL, 32'h10);
    wrs(datc_pkg::ADDR_EVT_EN, 32'h4);
    chk("mode_idle", DEBUG_MODE_O, 0);
    datc_probe_inst.request(1);
    for (i = 0; i < 100 && !PWR_ACK_O; i++) @(posedge CLK_I);
    tmo(PWR_ACK_O);
    chk("mode", DEBUG_MODE_O, 1);
    chk("wake", WAKE_O, 1);
    chk("irq", IRQ_O, 1);
    rd(datc_pkg::ADDR_EVT_STAT, d, r);
    chk("wake_evt", d[2], 1);
    wrs(datc_pkg::ADDR_EVT_EN, 32'h0);
    chk("irq_mask", IRQ_O, 0);
    wrs(datc_pkg::ADDR_EVT_EN, 32'h4);
    chk("irq_unmask", IRQ_O, 1);
    wrs(datc_pkg::ADDR_EVT_CLR, 32'h4);
    chk("irq_clr", IRQ_O, 0);
    wrs(datc_pkg::ADDR_CONTROL, 32'h20);
    chk("wake_clr", WAKE_O, 0);
    for (i = 0; i < 4; i++) begin
      wrs(datc_pkg::ADDR_CONTROL, i);
      chk("allow_sec", ALLOW_SECURE_O, i == 0);
      chk("allow_ns", ALLOW_NONSEC_O, !i[0]);
    end
    wrs(datc_pkg::ADDR_AP_REQ, 32'h0);
    chk("sel_locked", AP_SEL_O, 0);
    wrs(datc_pkg::ADDR_CONTROL, 32'h0);
    for (i = 0; i < 3; i++) begin
      wrs(datc_pkg::ADDR_AP_REQ, i == 0 ? 0 : i + 2);
      chk("ap_sel", AP_SEL_O, 3'b001 << i);
    end
    wrs(datc_pkg::ADDR_AP_REQ, 32'h600);
    rd(datc_pkg::ADDR_AP_RESP, d, r);
    chk("exec_read", d[1:0], 2'b10);
    wrs(datc_pkg::ADDR_AP_REQ, 32'h400);
    rd(datc_pkg::ADDR_AP_RESP, d, r);
    chk("plain_read", d[1:0], 2'b01);
    wrs(datc_pkg::ADDR_CONTROL, 32'h2);
    wrs(datc_pkg::ADDR_AP_REQ, 32'h100);
    rd(datc_pkg::ADDR_AP_RESP, d, r);
    chk("secure_req", d[1:0], 2'b01);
    wrs(datc_pkg::ADDR_CONTROL, 32'h0C);
    chk("pin_sel", TRACE_PIN_SEL_O, 1);
    chk("drive", HIGH_DRIVE_O, 1);
    // Drive frozen while the session runs
    wrs(datc_pkg::ADDR_CONTROL, 32'h4C);
    wrs(datc_pkg::ADDR_CONTROL, 32'h44);
    chk("drive_frozen", HIGH_DRIVE_O, 1);
    wrs(datc_pkg::ADDR_TRACE_CFG, 32'h1);
    datc_probe_inst.nibbles = 0;
    wr(datc_pkg::ADDR_TRACE_DAT, 32'h87654321, r);
    for (i = 0; i < 400 && datc_probe_inst.nibbles < 8; i++) @(posedge CLK_I);
    tmo(datc_probe_inst.nibbles == 8);
    chk("trace", datc_probe_inst.word_q, 32'h87654321);
    datc_probe_inst.request(0);
    repeat (6) @(posedge CLK_I);
    chk("mode_off", DEBUG_MODE_O, 0);
    chk("ack_off", PWR_ACK_O, 0);
    RESET_I <= 1;
    repeat (2) @(posedge CLK_I);
    RESET_I <= 0;
    @(posedge CLK_I);
    chk("pin_reset", {WAKE_O, HIGH_DRIVE_O, IRQ_O}, 0);
    tally_and_finish();
  end
endmodule : debug_access_and_trace_control_test
